// file: hdl/drsc_run_stop.v
`timescale 1ns/1ps
`default_nettype none
`include "drsc_defines.vh"
module drsc_run_stop #(
  parameter [31:0] OL_CYCLES = `DRSC_OL_CYCLES
) (
  input  wire        clk_sys_in,
  input  wire        reset_n_in,
  input  wire        term01_in,
  input  wire        term02_in,
  input  wire        term03_in,
  input  wire        hw_enable_in,
  input  wire        enbl_jumper_removed_in,
  input  wire        keypad_start_in,
  input  wire        keypad_stop_in,
  input  wire        keypad_reverse_in,
  input  wire        comm_start_in,
  input  wire        comm_stop_in,
  input  wire        comm_reverse_in,
  input  wire [2:0]  start_scheme_select_in,
  input  wire [2:0]  stop_behaviour_select_in,
  input  wire [11:0] min_output_frequency_in,
  input  wire [11:0] max_output_frequency_in,
  input  wire [11:0] freq_command_in,
  input  wire [11:0] motor_overload_current_setting_in,
  input  wire [11:0] output_current_in,
  input  wire        energy_tick_in,
  input  wire        meter_clear_in,
  input  wire        fault_in,
  output reg         run_out,
  output reg         reverse_out,
  output reg         outputs_ready_out,
  output reg         stop_active_out,
  output reg  [1:0]  stop_kind_out,
  output reg  [11:0] output_frequency_out,
  output reg         motor_overload_fault_out,
  output reg         fault_out,
  output reg  [9:0]  energy_kwh_counter_out,
  output reg  [15:0] energy_mwh_counter_out,
  output reg  [2:0]  active_scheme_out
);
  wire t01;
  wire t02;
  wire t03;
  wire t02_rise;
  wire t03_rise;
  wire hwen;
  wire [9:0]  kwh;
  wire [15:0] mwh;
  reg  [2:0]  scheme;
  reg  [2:0]  stop_sel;
  reg  [11:0] max_f;
  reg         armed;
  reg         running;
  reg         dir_rev;
  reg         ol_fault;
  reg         t01_fault;
  reg  [31:0] ol_cnt;
  wire        ol_over;
  reg         kp_start_d;
  reg         cm_start_d;
  reg         next_running;
  reg         next_rev;
  reg         start_ev;
  reg         run_req;
  reg         stop_req;
  reg         stop_t01;
  reg  [1:0]  next_kind;
  reg  [11:0] next_freq;
  reg  [23:0] ol_limit;
  wire        any_fault;
  wire        level_sch;
  // terminal synchronisers with edge detection
  drsc_sync #(.IDLE(1'b1)) u_sync01 ( // stop input idles high
    .clk_in     (clk_sys_in),
    .reset_n_in (reset_n_in),
    .pin_in     (term01_in),
    .level_out  (t01),
    .rise_out   ()
  );
  drsc_sync u_sync02 (
    .clk_in     (clk_sys_in),
    .reset_n_in (reset_n_in),
    .pin_in     (term02_in),
    .level_out  (t02),
    .rise_out   (t02_rise)
  );
  drsc_sync u_sync03 (
    .clk_in     (clk_sys_in),
    .reset_n_in (reset_n_in),
    .pin_in     (term03_in),
    .level_out  (t03),
    .rise_out   (t03_rise)
  );
  drsc_sync #(.IDLE(1'b1)) u_synchw ( // enable idles high
    .clk_in     (clk_sys_in),
    .reset_n_in (reset_n_in),
    .pin_in     (hw_enable_in),
    .level_out  (hwen),
    .rise_out   ()
  );
  // energy meter
  drsc_energy u_energy (
    .clk_in     (clk_sys_in),
    .reset_n_in (reset_n_in),
    .clear_in   (meter_clear_in),
    .tick_in    (energy_tick_in),
    .kwh_out    (kwh),
    .mwh_out    (mwh)
  );
  assign any_fault = ol_fault | t01_fault | fault_in;
  assign level_sch = (scheme == `DRSC_SCH_2W_LVL) ||
                     (scheme == `DRSC_SCH_2W_ENBL);
  // current above the overload limit; also blocks the clear of its fault
  assign ol_over = ({12'h000, output_current_in} > ol_limit);
  // run and stop decision per scheme
  always @* begin
    run_req = 1'b0;
    start_ev = 1'b0;
    stop_req = 1'b0;
    stop_t01 = 1'b0;
    next_rev = dir_rev;
    case (scheme)
      `DRSC_SCH_KEYPAD: begin
        start_ev = keypad_start_in & ~kp_start_d;
        stop_req = keypad_stop_in;
        stop_t01 = ~t01;
        if (start_ev) next_rev = keypad_reverse_in;
      end
      `DRSC_SCH_3WIRE: begin
        start_ev = t02_rise;
        stop_req = ~t01;
        next_rev = t03;
      end
      `DRSC_SCH_COMM: begin
        start_ev = comm_start_in & ~cm_start_d;
        stop_req = comm_stop_in;
        stop_t01 = ~t01;
        if (start_ev) next_rev = comm_reverse_in;
      end
      `DRSC_SCH_2W_ENBL: begin
        run_req = t02 & t03;
        stop_req = ~t02;
        stop_t01 = ~t01;
        next_rev = 1'b0;
      end
      default: begin
        // two-wire: 02 forward, 03 reverse
        start_ev = t02_rise | t03_rise;
        run_req = t02 ^ t03;
        stop_req = ~(t02 | t03);
        stop_t01 = ~t01;
        if (t02 ^ t03) next_rev = t03;
      end
    endcase
    // stop mode applies to all other sources; terminal 01 outside three-wire and a lost hardware enable coast
    next_kind = stop_sel[1:0];
    if (stop_t01 || (enbl_jumper_removed_in && !hwen)) begin
      next_kind = `DRSC_STOP_COAST;
    end
    next_running = running;
    if (stop_req || stop_t01 || any_fault ||
        (enbl_jumper_removed_in && !hwen)) begin
      next_running = 1'b0;
    end else if (level_sch) begin
      next_running = run_req;
    end else if (start_ev && armed) begin
      next_running = 1'b1;
    end else if (scheme != `DRSC_SCH_3WIRE &&
                 scheme != `DRSC_SCH_KEYPAD &&
                 scheme != `DRSC_SCH_COMM && !run_req) begin
      next_running = 1'b0;
    end
    // frequency clamp between minimum and maximum
    next_freq = freq_command_in;
    if (next_freq > max_f) next_freq = max_f;
    if (next_freq < min_output_frequency_in) begin
      next_freq = min_output_frequency_in;
    end
    if (!next_running) next_freq = 12'h000;
    ol_limit = motor_overload_current_setting_in * 12'd150 / 12'd100;
  end
  // settings latch only while stopped, controller stops first
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scheme <= `DRSC_SCH_RESET;
      stop_sel <= 3'h1;
      max_f <= `DRSC_FREQ_MAX_RST;
    end else if (!running) begin
      scheme <= (start_scheme_select_in > `DRSC_SCH_2W_ENBL) ?
                `DRSC_SCH_RESET : start_scheme_select_in;
      stop_sel <= stop_behaviour_select_in;
      max_f <= (max_output_frequency_in > `DRSC_FREQ_MAX_LIM) ?
               `DRSC_FREQ_MAX_LIM : max_output_frequency_in;
    end
  end
  // run state, arming and faults
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      running <= 1'b0;
      dir_rev <= 1'b0;
      armed <= 1'b1;
      kp_start_d <= 1'b1; // a button held through reset is no start
      cm_start_d <= 1'b1;
      t01_fault <= 1'b0;
      ol_fault <= 1'b0;
      ol_cnt <= 32'h0;
    end else begin
      kp_start_d <= keypad_start_in;
      cm_start_d <= comm_start_in;
      running <= next_running;
      if (next_running) dir_rev <= next_rev;
      // running disarms; once stopped, the first cycle without a start edge re-arms
      if (next_running) armed <= 1'b0;
      else if (!start_ev) armed <= 1'b1;
      // terminal 01 loss is a fault in scheme 6
      if (scheme == `DRSC_SCH_2W_ENBL && !t01) t01_fault <= 1'b1;
      else if (stop_req && !stop_sel[`DRSC_STOP_CF_BIT]) begin
        t01_fault <= 1'b0;
      end
      // overload timer
      if (ol_over) begin
        if (ol_cnt >= OL_CYCLES - 32'h1) ol_fault <= 1'b1;
        else ol_cnt <= ol_cnt + 32'h1;
      end else begin
        ol_cnt <= 32'h0;
      end
      if (stop_req && !stop_sel[`DRSC_STOP_CF_BIT] && !ol_over) begin
        ol_fault <= 1'b0;
      end
    end
  end
  // registered outputs
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_out <= 1'b0;
      reverse_out <= 1'b0;
      outputs_ready_out <= 1'b0;
      stop_active_out <= 1'b0;
      stop_kind_out <= `DRSC_STOP_COAST;
      output_frequency_out <= 12'h000;
      motor_overload_fault_out <= 1'b0;
      fault_out <= 1'b0;
      energy_kwh_counter_out <= 10'h000;
      energy_mwh_counter_out <= 16'h0000;
      active_scheme_out <= `DRSC_SCH_RESET;
    end else begin
      run_out <= next_running;
      reverse_out <= next_running ? next_rev : dir_rev;
      // ready-to-run held in high-speed scheme while no fault is present
      outputs_ready_out <= next_running ||
                           (scheme == `DRSC_SCH_2W_HS && !any_fault);
      stop_active_out <= running & ~next_running;
      if (running && !next_running) stop_kind_out <= next_kind;
      output_frequency_out <= next_freq;
      motor_overload_fault_out <= ol_fault;
      fault_out <= any_fault;
      energy_kwh_counter_out <= kwh;
      energy_mwh_counter_out <= mwh;
      active_scheme_out <= scheme;
    end
  end
endmodule // drsc_run_stop
`default_nettype wire

// file: hdl/drsc_defines.vh
`ifndef DRSC_DEFINES_VH
`define DRSC_DEFINES_VH
// start scheme codes
`define DRSC_SCH_KEYPAD   3'h0
`define DRSC_SCH_3WIRE    3'h1
`define DRSC_SCH_2WIRE    3'h2
`define DRSC_SCH_2W_LVL   3'h3
`define DRSC_SCH_2W_HS    3'h4
`define DRSC_SCH_COMM     3'h5
`define DRSC_SCH_2W_ENBL  3'h6
`define DRSC_SCH_RESET    3'h3
// stop kinds, low two bits of the stop selector
`define DRSC_STOP_RAMP    2'h0
`define DRSC_STOP_COAST   2'h1
`define DRSC_STOP_DCBRK   2'h2
`define DRSC_STOP_DCAUTO  2'h3
`define DRSC_STOP_CF_BIT  2
// frequencies in 0.1 Hz
`define DRSC_FREQ_MAX_LIM 12'hc80
`define DRSC_FREQ_MAX_RST 12'h258
// energy in 0.1 kWh; counter wraps after 100.0 kWh
`define DRSC_KWH_MAX      10'h3e8
// overload: 150 percent for 60 s
`define DRSC_OL_PCT       150
`define DRSC_OL_TIME_S    60
`define DRSC_CLK_HZ       50000000
`define DRSC_OL_CYCLES    (`DRSC_OL_TIME_S * `DRSC_CLK_HZ)
// high speed response, 10 ms
`define DRSC_HS_TIME_MS   10
`define DRSC_HS_CYCLES    (`DRSC_HS_TIME_MS * (`DRSC_CLK_HZ / 1000))
`endif

// file: hdl/drsc_sync.v
`timescale 1ns/1ps
`default_nettype none
// three-flop synchroniser with agreement filter and rising edge pulse
module drsc_sync #(
  parameter [0:0] IDLE = 1'b0
) (
  input  wire clk_in,
  input  wire reset_n_in,
  input  wire pin_in,
  output reg  level_out,
  output reg  rise_out
);
  reg       s1;
  reg       s2;
  reg       s3;
  reg [2:0] fill;
  reg       primed;
  // shift chain; level changes once second and third agree
  // no edge until the chain holds real samples: a pin held
  // through reset must not look like a fresh start
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1 <= IDLE;
      s2 <= IDLE;
      s3 <= IDLE;
      fill <= 3'h0;
      primed <= 1'b0;
      level_out <= IDLE;
      rise_out <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      fill <= {fill[1:0], 1'b1};
      rise_out <= 1'b0;
      if (s2 == s3 && fill[2]) begin
        level_out <= s3;
        primed <= 1'b1;
        rise_out <= s3 & ~level_out & primed;
      end
    end
  end
endmodule // drsc_sync
`default_nettype wire

// file: hdl/drsc_energy.v
`timescale 1ns/1ps
`default_nettype none
`include "drsc_defines.vh"
// kWh accumulator in 0.1 kWh steps rolling into MWh counter
module drsc_energy (
  input  wire        clk_in,
  input  wire        reset_n_in,
  input  wire        clear_in,
  input  wire        tick_in,
  output reg  [9:0]  kwh_out,
  output reg  [15:0] mwh_out
);
  // wrap at 100.0 kWh and carry one unit
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      kwh_out <= 10'h000;
      mwh_out <= 16'h0000;
    end else if (clear_in) begin
      kwh_out <= 10'h000;
      mwh_out <= 16'h0000;
    end else if (tick_in) begin
      if (kwh_out >= `DRSC_KWH_MAX - 10'h001) begin
        kwh_out <= 10'h000;
        mwh_out <= mwh_out + 16'h0001;
      end else begin
        kwh_out <= kwh_out + 10'h001;
      end
    end
  end
endmodule // drsc_energy
`default_nettype wire

// file: verif/drsc_run_stop_props.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the run/stop block
module drsc_run_stop_props #(
  parameter [31:0] OL_CYCLES = 32'd100
) (
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  input wire logic        term01_in,
  input wire logic [11:0] min_output_frequency_in,
  input wire logic [11:0] max_output_frequency_in,
  input wire logic [11:0] motor_overload_current_setting_in,
  input wire logic [11:0] output_current_in,
  input wire logic        meter_clear_in,
  input wire logic        run_out,
  input wire logic        stop_active_out,
  input wire logic [1:0]  stop_kind_out,
  input wire logic [11:0] output_frequency_out,
  input wire logic        motor_overload_fault_out,
  input wire logic        fault_out,
  input wire logic [9:0]  energy_kwh_counter_out,
  input wire logic [15:0] energy_mwh_counter_out,
  input wire logic [2:0]  active_scheme_out
);
  // current above 150 percent of the setting: 2 * current > 3 * setting
  wire over = {1'b0, output_current_in, 1'b0} >
    motor_overload_current_setting_in * 14'd3;
  reg [31:0] ol_cnt;
  reg [3:0]  lo_cnt;
  // run lengths of overload and of terminal 01 held low
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ol_cnt <= 32'h0;
      lo_cnt <= 4'h0;
    end else begin
      ol_cnt <= over ? ol_cnt + 32'h1 : 32'h0;
      lo_cnt <= term01_in ? 4'h0 : lo_cnt + {3'h0, lo_cnt != 4'hf};
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // a clear reaches the meter outputs two edges after it is sampled
  sequence s_kwh_top;
    energy_kwh_counter_out == 10'h3e7 && !$past(meter_clear_in);
  endsequence
  sequence s_wrap;
    energy_kwh_counter_out == 10'h0 &&
      energy_mwh_counter_out == $past(energy_mwh_counter_out) + 16'h1;
  endsequence
  a_mwh_only_wrap: assert property (
    $changed(energy_mwh_counter_out) && !$past(meter_clear_in, 2) |-> s_wrap)
    else $error("mwh moved without kwh wrap");
  a_kwh_rolls_over: assert property (
    s_kwh_top ##1 energy_kwh_counter_out != 10'h3e7 |-> s_wrap)
    else $error("kwh left top without wrap");
  a_ol_not_early: assert property (
    $rose(motor_overload_fault_out) |-> ol_cnt >= OL_CYCLES)
    else $error("overload fault too early");
  a_ol_not_late: assert property (
    ol_cnt == OL_CYCLES + 32'd4 |-> motor_overload_fault_out)
    else $error("overload fault missing");
  a_freq_below_max: assert property (
    run_out && $past(run_out) |->
      output_frequency_out <= max_output_frequency_in &&
      output_frequency_out <= 12'hc80)
    else $error("frequency above maximum");
  a_freq_above_min: assert property (
    run_out && $past(run_out) &&
      min_output_frequency_in <= max_output_frequency_in |->
      output_frequency_out >= min_output_frequency_in)
    else $error("frequency below minimum");
  a_t01_coasts: assert property (
    stop_active_out && lo_cnt >= 4'h3 && active_scheme_out != 3'h1 |=>
      stop_kind_out == 2'h1)
    else $error("terminal 01 stop did not coast");
  a_fault_holds_stop: assert property (
    fault_out [*2] |-> !run_out)
    else $error("running while faulted");
endmodule // drsc_run_stop_props
bind drsc_run_stop drsc_run_stop_props #(.OL_CYCLES(OL_CYCLES)) u_props (
  .clk_sys_in, .reset_n_in, .term01_in, .min_output_frequency_in,
  .max_output_frequency_in, .motor_overload_current_setting_in,
  .output_current_in, .meter_clear_in, .run_out, .stop_active_out,
  .stop_kind_out, .output_frequency_out, .motor_overload_fault_out,
  .fault_out, .energy_kwh_counter_out, .energy_mwh_counter_out,
  .active_scheme_out);
`default_nettype wire

// file: verif/drsc_op.sv
`timescale 1ns/1ps
`default_nettype none
// operator side: new settings reach the drive only while it is stopped
module drsc_op (
  input  wire logic        clk_in,
  input  wire logic        run_in,
  input  wire logic [2:0]  sch_in,
  input  wire logic [2:0]  mode_in,
  input  wire logic [11:0] max_in,
  input  wire logic [11:0] min_in,
  output var  logic [2:0]  sch_out = 3'h3,
  output var  logic [2:0]  mode_out = 3'h1,
  output var  logic [11:0] max_out = 12'h258,
  output var  logic [11:0] min_out = 12'h0
);
  // settings wait while the motor runs
  always @(posedge clk_in) begin
    if (!run_in) begin
      sch_out <= sch_in;
      mode_out <= mode_in;
      max_out <= max_in;
      min_out <= min_in;
    end
  end
endmodule // drsc_op
`default_nettype wire

// file: verif/drsc_run_stop_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module drsc_run_stop_tb_top;
  localparam int OLC = 40;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, term01_in = 1'b1;
  logic term02_in = 1'b0, term03_in = 1'b0, hw_enable_in = 1'b1;
  logic enbl_jumper_removed_in = 1'b0, keypad_start_in = 1'b0;
  logic keypad_stop_in = 1'b0, fault_in = 1'b0;
  logic comm_start_in = 1'b0, comm_stop_in = 1'b0, energy_tick_in = 1'b0;
  logic meter_clear_in = 1'b0, run_out, reverse_out, outputs_ready_out;
  logic stop_active_out, motor_overload_fault_out, fault_out;
  logic [1:0]  stop_kind_out;
  logic [2:0]  start_scheme_select_in, stop_behaviour_select_in;
  logic [2:0]  active_scheme_out, sch = 3'h3, mode = 3'h1;
  logic [11:0] min_output_frequency_in, max_output_frequency_in, f;
  logic [11:0] mx = 12'h258, mn = 12'h0, freq_command_in = 12'h0;
  logic [11:0] motor_overload_current_setting_in = 12'h64;
  logic [11:0] output_current_in = 12'h0, output_frequency_out;
  logic [9:0]  energy_kwh_counter_out;
  logic [15:0] energy_mwh_counter_out;
  int err_total = 0, checks = 0, cyc = 0, n;
  drsc_run_stop #(.OL_CYCLES(OLC)) drsc_run_stop_inst (
    .clk_sys_in, .reset_n_in, .term01_in, .term02_in, .term03_in,
    .hw_enable_in, .enbl_jumper_removed_in, .keypad_start_in,
    .keypad_stop_in, .keypad_reverse_in(1'b0), .comm_start_in,
    .comm_stop_in, .comm_reverse_in(1'b0), .start_scheme_select_in,
    .stop_behaviour_select_in, .min_output_frequency_in,
    .max_output_frequency_in, .freq_command_in,
    .motor_overload_current_setting_in, .output_current_in,
    .energy_tick_in, .meter_clear_in, .fault_in, .run_out,
    .reverse_out, .outputs_ready_out, .stop_active_out, .stop_kind_out,
    .output_frequency_out, .motor_overload_fault_out, .fault_out,
    .energy_kwh_counter_out, .energy_mwh_counter_out, .active_scheme_out);
  drsc_op drsc_op_inst (.clk_in(clk_sys_in), .run_in(run_out),
    .sch_in(sch), .mode_in(mode), .max_in(mx), .min_in(mn),
    .sch_out(start_scheme_select_in), .mode_out(stop_behaviour_select_in),
    .max_out(max_output_frequency_in), .min_out(min_output_frequency_in));
  always #10 clk_sys_in = ~clk_sys_in;
  // cycle ceiling against hangs
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
    #2;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // command clamped to the limits, maximum itself capped at 320.0 Hz
  function automatic logic [11:0] exp_f(input logic [11:0] c, lo, hi);
    logic [11:0] m;
    m = hi > 12'hc80 ? 12'hc80 : hi;
    m = c > m ? m : c;
    return m < lo ? lo : m;
  endfunction
  initial begin
    n = $urandom(32'h2591);
    tick(8);
    // one pass per start scheme, each behind a fresh reset
    for (int s = 0; s < 7; s++) begin
      reset_n_in = 1'b0;
      sch = 3'(s);
      mode = 3'($urandom % 8);
      mx = 12'($urandom % 4096);
      mn = 12'($urandom % ((mx > 12'hc80 ? 32'hc80 : 32'(mx)) + 1));
      freq_command_in = 12'($urandom % 4096);
      tick(2);
      reset_n_in = 1'b1;
      tick(12);
      term02_in = 1'b1;
      term03_in = (s == 1 || s == 6);
      tick(12);
      chk("run_term", run_out, s != 0 && s != 5);
      if (s == 4) chk("ready", outputs_ready_out, 1);
      keypad_start_in = (s == 0);
      comm_start_in = (s == 5);
      tick(2);
      keypad_start_in = 1'b0;
      comm_start_in = 1'b0;
      tick(12);
      f = exp_f(freq_command_in, mn, mx);
      chk("run", run_out, 1);
      chk("dir", reverse_out, s == 1);
      chk("freq", output_frequency_out, f);
      chk("scheme", active_scheme_out, 16'(s));
      enbl_jumper_removed_in = (s == 4);
      hw_enable_in = (s != 4);
      comm_stop_in = (s == 5);
      term01_in = (s == 4 || s == 5);
      tick(12);
      chk("stopped", run_out, 0);
      f = (s == 1 || s == 5) ? mode[1:0] : 2'h1;
      chk("kind", stop_kind_out, f);
      chk("fault", fault_out, s == 6);
      term01_in = 1'b1;
      comm_stop_in = 1'b0;
      enbl_jumper_removed_in = 1'b0;
      hw_enable_in = 1'b1;
      tick(12);
      if (s != 6) chk("restart", run_out, s == 3);
      // keypad stop follows the stop mode, not a coast
      if (s == 0) begin
        keypad_start_in = 1'b1;
        tick(2);
        chk("kp_run", run_out, 1);
        keypad_start_in = 1'b0;
        keypad_stop_in = 1'b1;
        tick(4);
        chk("kp_stop", run_out, 0);
        chk("kp_kind", stop_kind_out, mode[1:0]);
        keypad_stop_in = 1'b0;
      end
      // level scheme with run held resumes once the fault is gone
      if (s == 3) begin
        fault_in = 1'b1;
        tick(4);
        chk("flt_stop", run_out, 0);
        chk("flt_seen", fault_out, 1);
        fault_in = 1'b0;
        tick(4);
        chk("flt_resume", run_out, 1);
      end
      term02_in = 1'b0;
      tick(8);
      term02_in = 1'b1;
      tick(12);
      if (s == 2) chk("edge", run_out, 1);
      term02_in = 1'b0;
      term03_in = 1'b0;
    end
    // overload: exactly 150 percent holds off, one step above trips
    motor_overload_current_setting_in = 12'(2 * ($urandom % 1000) + 20);
    output_current_in = 12'((32'(motor_overload_current_setting_in) * 3) / 2);
    tick(OLC + 20);
    chk("ol_edge", motor_overload_fault_out, 0);
    output_current_in = output_current_in + 12'h1;
    tick(OLC + 8);
    chk("ol", motor_overload_fault_out, 1);
    output_current_in = 12'h0;
    // energy: a full 100.0 kWh plus a random remainder
    meter_clear_in = 1'b1;
    tick(1);
    meter_clear_in = 1'b0;
    n = $urandom % 50;
    energy_tick_in = 1'b1;
    tick(1000 + n);
    energy_tick_in = 1'b0;
    tick(3);
    chk("kwh", energy_kwh_counter_out, 16'(n));
    chk("mwh", energy_mwh_counter_out, 1);
    report_and_stop();
  end
endmodule // drsc_run_stop_tb_top
`default_nettype wire
